// ### adc_flags_pkg.sv
// Purpose: Shared constants and types of the converter result and flag block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   Offsets are byte addresses; channel count must not exceed 8

package adc_flags_pkg;

   // ----------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------
   localparam int NUM_CH_DEF = 8;
   localparam int RES_BITS_DEF = 10;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_MODE = 8'h04;
   localparam logic [7:0] OFS_CH_EN = 8'h10;
   localparam logic [7:0] OFS_CH_DIS = 8'h14;
   localparam logic [7:0] OFS_CH_STAT = 8'h18;
   localparam logic [7:0] OFS_STAT = 8'h1C;
   localparam logic [7:0] OFS_LAST = 8'h20;
   localparam logic [7:0] OFS_EVT = 8'h30;
   localparam logic [7:0] OFS_MASK = 8'h34;
   localparam logic [7:0] OFS_CDR0 = 8'h40;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int CTRL_START_BIT = 1;
   localparam int MODE_SLEEP_BIT = 5;
   localparam int STAT_OVR_POS = 8;
   localparam int STAT_NEWDATA_BIT = 16;
   localparam int STAT_GOVR_BIT = 17;
   localparam int LAST_CH_POS = 12;
   localparam int EVT_DONE_BIT = 0;
   localparam int EVT_OVR_BIT = 1;
   localparam int EVT_GOVR_BIT = 2;
   localparam int EVT_W = 3;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [EVT_W-1:0] MASK_RST = 3'h0;

   typedef enum logic [0:0] {
      BUS_IDLE = 1'b0,
      BUS_ACK = 1'b1
   } bus_state_type;

endpackage

// ### adc_apb_port.sv
// Purpose: APB slave handshake; one wait state, then ready
// Assumes: Master holds the request until ready is seen
// Notes:   Strobes fire at the edge ending the first access cycle

`timescale 1ns/1ps
`default_nettype none

module adc_apb_port
   import adc_flags_pkg::*;
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rstn,
   // Bus request
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic i_mapped,
   // Bus answer
   output logic o_pready,
   output logic o_pslverr,
   // Register strobes
   output logic o_wr,
   output logic o_rd
);

   typedef struct packed {
      bus_state_type st;
      logic err;
   } port_state_type;

   port_state_type s;
   port_state_type next_s;

   always_comb begin
      next_s = s;
      o_wr = 1'b0;
      o_rd = 1'b0;
      case (s.st)
         BUS_IDLE: begin
            // Side effects and read capture happen together, so a read
            // never clears a flag it did not show
            if (i_psel && i_penable) begin
               next_s.st = BUS_ACK;
               next_s.err = ~i_mapped;
               o_wr = i_pwrite & i_mapped;
               o_rd = ~i_pwrite & i_mapped;
            end
         end
         BUS_ACK: begin
            next_s.st = BUS_IDLE;
         end
         default: begin
            next_s.st = BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         s <= '{st: BUS_IDLE, err: 1'b0};
      end else begin
         s <= next_s;
      end
   end

   assign o_pready = (s.st == BUS_ACK);
   assign o_pslverr = (s.st == BUS_ACK) & s.err;

endmodule

`default_nettype wire

// ### adc_chan_flags.sv
// Purpose: Done and overrun flags of one converter channel
// Assumes: i_store only pulses for an enabled channel
// Notes:   A new result always beats a clear in the same cycle

`timescale 1ns/1ps
`default_nettype none

module adc_chan_flags (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rstn,
   // Events
   input wire logic i_store,
   input wire logic i_clr_done,
   input wire logic i_stat_read,
   // Flags
   output logic o_done,
   output logic o_ovr,
   output logic o_new_ovr
);

   typedef struct packed {
      logic done;
      logic ovr;
   } flag_state_type;

   flag_state_type s;
   flag_state_type next_s;

   always_comb begin
      next_s = s;
      // Unread result still pending when the next one lands
      o_new_ovr = i_store & s.done & ~i_clr_done;
      next_s.done = (s.done & ~i_clr_done) | i_store;
      // Status read clears overrun, but a new overrun in the same cycle wins
      next_s.ovr = (s.ovr & ~i_stat_read) | o_new_ovr;
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign o_done = s.done;
   assign o_ovr = s.ovr;

endmodule

`default_nettype wire

// ### adc_result_status_flags.sv
// Purpose: Result registers and status flags of a multi-channel converter
// Assumes: One end-of-conversion pulse per result, synchronous to I_CLK
// Notes:   Channel count at most 8; reads take one wait state on APB

`timescale 1ns/1ps
`default_nettype none

module adc_result_status_flags
   import adc_flags_pkg::*;
#(
   parameter int NUM_CH = NUM_CH_DEF,
   parameter int RES_BITS = RES_BITS_DEF
) (
   // Clock and reset
   input wire logic I_CLK,
   input wire logic I_RSTN,
   // APB slave
   input wire logic I_PSEL,
   input wire logic I_PENABLE,
   input wire logic I_PWRITE,
   input wire logic [ADDR_W-1:0] I_PADDR,
   input wire logic [DATA_W-1:0] I_PWDATA,
   output logic [DATA_W-1:0] O_PRDATA,
   output logic O_PREADY,
   output logic O_PSLVERR,
   // Conversion core
   input wire logic I_EOC,
   input wire logic [$clog2(NUM_CH)-1:0] I_EOC_CH,
   input wire logic [RES_BITS-1:0] I_EOC_DATA,
   output logic [NUM_CH-1:0] O_CH_EN,
   output logic O_START,
   output logic O_SLEEP,
   // Interrupt
   output logic O_IRQ
);

   localparam int CH_W = $clog2(NUM_CH);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [NUM_CH-1:0] en;
      logic [NUM_CH-1:0][RES_BITS-1:0] channel_result_register;
      logic [RES_BITS-1:0] last_data;
      logic [CH_W-1:0] last_ch;
      logic new_data;
      logic govr;
      logic sleep_sel;
      logic sleep_act;
      logic start;
      logic [EVT_W-1:0] evt;
      logic [EVT_W-1:0] mask;
      logic [DATA_W-1:0] rdata;
   } state_type;

   state_type s;
   state_type next_s;

   logic bus_wr;
   logic bus_rd;
   logic mapped;
   logic is_cdr;
   logic [ADDR_W-1:0] cdr_ofs;
   logic [CH_W-1:0] cdr_sel;
   logic rd_last;
   logic rd_stat;
   logic rd_cdr;
   logic [NUM_CH-1:0] dis_mask;
   logic [NUM_CH-1:0] ena_mask;
   logic eoc_ok;
   logic [NUM_CH-1:0] store_vec;
   logic [NUM_CH-1:0] clr_done;
   logic [NUM_CH-1:0] done;
   logic [NUM_CH-1:0] ovr;
   logic [NUM_CH-1:0] new_ovr;
   logic new_govr;
   logic [DATA_W-1:0] rd_val;

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   always_comb begin
      cdr_ofs = I_PADDR - OFS_CDR0;
      is_cdr = (I_PADDR >= OFS_CDR0) && (cdr_ofs[ADDR_W-1:2] < ADDR_W'(NUM_CH));
      cdr_sel = cdr_ofs[CH_W+1:2];
      mapped = 1'b0;
      if (I_PADDR[1:0] == 2'h0) begin
         case (I_PADDR)
            OFS_CTRL, OFS_MODE, OFS_CH_EN, OFS_CH_DIS, OFS_CH_STAT,
            OFS_STAT, OFS_LAST, OFS_EVT, OFS_MASK: begin
               mapped = 1'b1;
            end
            default: begin
               mapped = is_cdr;
            end
         endcase
      end
   end

   adc_apb_port u_port (
      .i_clk(I_CLK),
      .i_rstn(I_RSTN),
      .i_psel(I_PSEL),
      .i_penable(I_PENABLE),
      .i_pwrite(I_PWRITE),
      .i_mapped(mapped),
      .o_pready(O_PREADY),
      .o_pslverr(O_PSLVERR),
      .o_wr(bus_wr),
      .o_rd(bus_rd)
   );

   // ----------------------------------------------------------------
   // Read and write side effects
   // ----------------------------------------------------------------
   always_comb begin
      rd_last = bus_rd && (I_PADDR == OFS_LAST);
      rd_stat = bus_rd && (I_PADDR == OFS_STAT);
      rd_cdr = bus_rd && is_cdr;
      dis_mask = (bus_wr && (I_PADDR == OFS_CH_DIS)) ? I_PWDATA[NUM_CH-1:0] : '0;
      ena_mask = (bus_wr && (I_PADDR == OFS_CH_EN)) ? I_PWDATA[NUM_CH-1:0] : '0;
      // Only the converted channel's own enable matters; a disable of it in
      // this same cycle counts as already disabled
      eoc_ok = I_EOC & s.en[I_EOC_CH] & ~dis_mask[I_EOC_CH];
      store_vec = '0;
      store_vec[I_EOC_CH] = eoc_ok;
      clr_done = '0;
      if (rd_cdr) begin
         clr_done[cdr_sel] = 1'b1;
      end
      if (rd_last) begin
         clr_done[s.last_ch] = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Per-channel flags
   // ----------------------------------------------------------------
   for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
      adc_chan_flags u_flags (
         .i_clk(I_CLK),
         .i_rstn(I_RSTN),
         .i_store(store_vec[ch]),
         .i_clr_done(clr_done[ch]),
         .i_stat_read(rd_stat),
         .o_done(done[ch]),
         .o_ovr(ovr[ch]),
         .o_new_ovr(new_ovr[ch])
      );
   end

   // ----------------------------------------------------------------
   // Read data mux
   // ----------------------------------------------------------------
   always_comb begin
      rd_val = '0;
      case (I_PADDR)
         OFS_MODE: begin
            rd_val[MODE_SLEEP_BIT] = s.sleep_sel;
         end
         OFS_CH_STAT: begin
            rd_val[NUM_CH-1:0] = s.en;
         end
         OFS_STAT: begin
            rd_val[NUM_CH-1:0] = done;
            rd_val[STAT_OVR_POS +: NUM_CH] = ovr;
            rd_val[STAT_NEWDATA_BIT] = s.new_data;
            rd_val[STAT_GOVR_BIT] = s.govr;
         end
         OFS_LAST: begin
            rd_val[RES_BITS-1:0] = s.last_data;
            rd_val[LAST_CH_POS +: CH_W] = s.last_ch;
         end
         OFS_EVT: begin
            rd_val[EVT_W-1:0] = s.evt;
         end
         OFS_MASK: begin
            rd_val[EVT_W-1:0] = s.mask;
         end
         default: begin
            if (is_cdr) begin
               rd_val[RES_BITS-1:0] = s.channel_result_register[cdr_sel];
            end
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      next_s = s;
      next_s.start = 1'b0;
      if (bus_rd) begin
         next_s.rdata = rd_val;
      end

      // Result storage
      if (eoc_ok) begin
         next_s.channel_result_register[I_EOC_CH] = I_EOC_DATA;
         next_s.last_data = I_EOC_DATA;
         next_s.last_ch = I_EOC_CH;
      end

      // Global overrun: new-data still pending and not being consumed now.
      // Channel reads and other disables do not mask it.
      new_govr = eoc_ok & s.new_data & ~rd_last;
      next_s.govr = (s.govr & ~rd_stat) | new_govr;

      // New-data: only last-result reads clear it; a stored result wins
      next_s.new_data = (s.new_data & ~rd_last) | eoc_ok;

      // Channel enables
      next_s.en = (s.en | ena_mask) & ~dis_mask;

      // Control and mode
      if (bus_wr && (I_PADDR == OFS_CTRL)) begin
         next_s.start = I_PWDATA[CTRL_START_BIT];
      end
      if (bus_wr && (I_PADDR == OFS_MODE)) begin
         next_s.sleep_sel = I_PWDATA[MODE_SLEEP_BIT];
      end
      // Sleep waits for a conversion to finish; idle selection alone
      // does not power down
      if (!next_s.sleep_sel) begin
         next_s.sleep_act = 1'b0;
      end else if (I_EOC) begin
         next_s.sleep_act = 1'b1;
      end

      // Sticky events, write one to clear; a new event beats the clear
      if (bus_wr && (I_PADDR == OFS_EVT)) begin
         next_s.evt = s.evt & ~I_PWDATA[EVT_W-1:0];
      end
      next_s.evt[EVT_DONE_BIT] = next_s.evt[EVT_DONE_BIT] | eoc_ok;
      next_s.evt[EVT_OVR_BIT] = next_s.evt[EVT_OVR_BIT] | (|new_ovr);
      next_s.evt[EVT_GOVR_BIT] = next_s.evt[EVT_GOVR_BIT] | new_govr;
      if (bus_wr && (I_PADDR == OFS_MASK)) begin
         next_s.mask = I_PWDATA[EVT_W-1:0];
      end
   end

   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         s <= '0;
         s.mask <= MASK_RST;
      end else begin
         s <= next_s;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign O_PRDATA = s.rdata;
   assign O_CH_EN = s.en;
   assign O_START = s.start;
   assign O_SLEEP = s.sleep_act;
   assign O_IRQ = |(s.evt & s.mask);

endmodule

`default_nettype wire

// ### adc_flags_props.sv
// Purpose: Port-level checks of the converter flag block
// Assumes: One clock domain, asynchronous active-low reset
// Notes:   Bound to the top module at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module adc_flags_props
   import adc_flags_pkg::*;
#(
   parameter int NUM_CH = NUM_CH_DEF,
   parameter int RES_BITS = RES_BITS_DEF
) (
   // Clock and reset
   input wire logic I_CLK,
   input wire logic I_RSTN,
   // Bus
   input wire logic I_PSEL,
   input wire logic I_PENABLE,
   input wire logic I_PWRITE,
   input wire logic [ADDR_W-1:0] I_PADDR,
   input wire logic [DATA_W-1:0] I_PWDATA,
   input wire logic O_PREADY,
   // Converter side
   input wire logic I_EOC,
   input wire logic [NUM_CH-1:0] O_CH_EN,
   input wire logic O_START,
   input wire logic O_SLEEP,
   input wire logic O_IRQ
);
   default clocking dcb @(posedge I_CLK);
   endclocking
   default disable iff (!I_RSTN);
   // -----------------------------------------------------------
   // Access edge helpers
   // -----------------------------------------------------------
   wire logic acc = I_PSEL && I_PENABLE && !O_PREADY;
   wire logic wr = acc && I_PWRITE;
   wire logic ev = I_EOC || wr;
   // -----------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------
   chk_ready_follows: assert property (acc |=> O_PREADY)
      else $error("ready missing after access");
   chk_ready_single: assert property (O_PREADY |=> !O_PREADY)
      else $error("ready longer than one cycle");
   chk_start_cause: assert property (O_START |->
      O_PREADY && $past(wr && I_PADDR == OFS_CTRL && I_PWDATA[CTRL_START_BIT]))
      else $error("start pulse without start write");
   chk_start_single: assert property (O_START |=> !O_START)
      else $error("start pulse too long");
   chk_sleep_cause: assert property ($rose(O_SLEEP) |-> $past(I_EOC))
      else $error("sleep entered without a conversion");
   chk_dis_clears: assert property (wr && I_PADDR == OFS_CH_DIS |=>
      (O_CH_EN & $past(I_PWDATA[NUM_CH-1:0])) == '0)
      else $error("channel still enabled after disable");
   chk_en_sets: assert property (wr && I_PADDR == OFS_CH_EN |=>
      (O_CH_EN & $past(I_PWDATA[NUM_CH-1:0])) == $past(I_PWDATA[NUM_CH-1:0]))
      else $error("channel not enabled after enable");
   chk_en_stable: assert property (!wr |=> $stable(O_CH_EN))
      else $error("enables changed without a write");
   chk_irq_cause: assert property ($rose(O_IRQ) |-> $past(ev) || $past(ev, 2))
      else $error("interrupt rose without a cause");
   cov_read_eoc: cover property (acc && !I_PWRITE && I_EOC);
   cov_irq: cover property ($rose(O_IRQ));
   cov_sleep: cover property ($rose(O_SLEEP));
endmodule
bind adc_result_status_flags adc_flags_props #(.NUM_CH(NUM_CH), .RES_BITS(RES_BITS)) chk_i (
   .I_CLK(I_CLK), .I_RSTN(I_RSTN), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
   .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA), .O_PREADY(O_PREADY),
   .I_EOC(I_EOC), .O_CH_EN(O_CH_EN), .O_START(O_START), .O_SLEEP(O_SLEEP), .O_IRQ(O_IRQ));
`default_nettype wire

// ### conv_core_model.sv
// Purpose: Behavioural conversion core facing the flag block
// Assumes: Bench asks for one result at a time
// Notes:   Result lines toggle when idle, so stale values never pass
`timescale 1ns/1ps
`default_nettype none
module conv_core_model #(
   parameter int START_LAT = 5,
   parameter logic [9:0] START_DATA = 10'h2A5
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rstn,
   // Requests
   input wire logic i_req,
   input wire logic [2:0] i_ch,
   input wire logic [9:0] i_data,
   input wire logic i_start,
   // Result
   output logic o_eoc,
   output logic [2:0] o_ch,
   output logic [9:0] o_data
);
   int cnt;
   always @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         cnt <= 0;
         o_eoc <= 1'b0;
         o_ch <= 3'h0;
         o_data <= 10'h0;
      end else begin
         o_eoc <= 1'b0;
         o_ch <= ~o_ch;
         o_data <= ~o_data;
         if (cnt > 0) cnt <= cnt - 1;
         if (i_start) cnt <= START_LAT;
         if (cnt == 1 || i_req) begin
            o_eoc <= 1'b1;
            o_ch <= i_req ? i_ch : 3'h0;
            o_data <= i_req ? i_data : START_DATA;
         end
      end
   end
endmodule
`default_nettype wire

// ### tb.sv
// Purpose: Self-checking bench of the converter flag block
// Assumes: Reference model below follows the flag semantics
// Notes:   Every read, the enables and the interrupt are compared
`timescale 1ns/1ps
`default_nettype none
module tb;
   import adc_flags_pkg::*;
   localparam logic [9:0] SDATA = 10'h2A5;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic req = 1'b0;
   logic [2:0] rch = 3'h0;
   logic [9:0] rdat = 10'h0;
   logic [31:0] prdata;
   logic pready, pslverr, eoc, start, sleep, irq;
   logic [2:0] ech;
   logic [9:0] edat;
   logic [7:0] chen;
   logic [31:0] seed = 32'h36;
   logic [31:0] prev = 32'h0;
   logic [31:0] r;
   int failures = 0;
   int num_checks = 0;
   int n;
   int en, dn, ov, nd, gv, lch, ldat, evt, msk;
   int channel_result_register [8];
   logic [7:0] rtab [4] = '{OFS_STAT, OFS_LAST, OFS_EVT, OFS_CH_STAT};
   logic [7:0] wtab [4] = '{OFS_CH_EN, OFS_CH_DIS, OFS_EVT, OFS_MASK};
   adc_result_status_flags dut (.I_CLK(clk), .I_RSTN(rstn), .I_PSEL(psel),
      .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
      .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .I_EOC(eoc),
      .I_EOC_CH(ech), .I_EOC_DATA(edat), .O_CH_EN(chen), .O_START(start),
      .O_SLEEP(sleep), .O_IRQ(irq));
   conv_core_model #(.START_DATA(SDATA)) core (.i_clk(clk), .i_rstn(rstn), .i_req(req),
      .i_ch(rch), .i_data(rdat), .i_start(start), .o_eoc(eoc), .o_ch(ech), .o_data(edat));
   always #5 clk = ~clk;
   // -----------------------------------------------------------
   // Reference model
   // -----------------------------------------------------------
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic bit mapped(logic [7:0] a);
      return a inside {OFS_CTRL, OFS_MODE, OFS_CH_EN, OFS_CH_DIS, OFS_CH_STAT, OFS_STAT,
         OFS_LAST, OFS_EVT, OFS_MASK} || (a >= OFS_CDR0 && a < 8'h60 && a[1:0] == 2'h0);
   endfunction
   function automatic int m_rd(logic [7:0] a);
      case (a)
         OFS_CH_STAT: return en;
         OFS_STAT: return dn | ov << 8 | nd << 16 | gv << 17;
         OFS_LAST: return ldat | lch << 12;
         OFS_EVT: return evt;
         OFS_MASK: return msk;
         default: return channel_result_register[(a - OFS_CDR0) / 4 % 8];
      endcase
   endfunction
   task automatic m_step(bit w, bit rd, logic [7:0] a, int wd, bit e, int c, int d);
      bit st, no, ng;
      int clr;
      st = e && en[c] && !(w && a == OFS_CH_DIS && wd[c]);
      clr = 0;
      if (rd && a == OFS_LAST) clr = 1 << lch;
      if (rd && a >= OFS_CDR0) clr = 1 << ((a - OFS_CDR0) / 4);
      no = st && dn[c] && !clr[c];
      ng = st && nd && !(rd && a == OFS_LAST);
      dn = dn & ~clr;
      if (rd && a == OFS_LAST) nd = 0;
      if (rd && a == OFS_STAT) ov = 0;
      if (rd && a == OFS_STAT) gv = 0;
      if (w && a == OFS_EVT) evt = evt & ~wd;
      if (w && a == OFS_CH_EN) en = (en | wd) & 'hFF;
      if (w && a == OFS_CH_DIS) en = en & ~wd;
      if (w && a == OFS_MASK) msk = wd & 7;
      if (st) begin
         dn = dn | 1 << c;
         nd = 1;
         channel_result_register[c] = d;
         lch = c;
         ldat = d;
         evt = evt | 1;
      end
      if (no) ov = ov | 1 << c;
      if (no) evt = evt | 2;
      if (ng) gv = 1;
      if (ng) evt = evt | 4;
   endtask
   // -----------------------------------------------------------
   // Checking and bus tasks
   // -----------------------------------------------------------
   task automatic conclude();
      $display("checks=%0d failures=%0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chk(logic [31:0] g, logic [31:0] x);
      num_checks++;
      if (g !== x) begin
         failures++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, x);
      end
   endtask
   task automatic apb(bit w, logic [7:0] a, logic [31:0] wd, bit e, logic [2:0] c,
      logic [9:0] d);
      logic [31:0] x;
      bit ok;
      ok = mapped(a);
      x = ok ? m_rd(a) : prev;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      req <= e;
      rch <= c;
      rdat <= d;
      @(posedge clk);
      penable <= 1'b1;
      req <= 1'b0;
      m_step(w && ok, !w && ok, a, wd, e, c, d);
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) failures++;
      if (n >= 20) conclude();
      chk(32'(pslverr), 32'(!ok));
      if (!w) chk(prdata, x);
      if (!w) prev = x;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
      chk(32'(irq), 32'((evt & msk) != 0));
      chk(32'(chen), en);
   endtask
   // -----------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------
   initial begin
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      apb(0, OFS_STAT, 0, 0, 0, 0);
      apb(0, OFS_EVT, 0, 0, 0, 0);
      apb(1, OFS_MASK, 32'h7, 0, 0, 0);
      apb(1, OFS_CH_EN, 32'h0F, 0, 0, 0);
      apb(0, OFS_STAT, 0, 1, 3'h1, 10'h155);
      apb(0, OFS_STAT, 0, 1, 3'h3, 10'h0AA);
      apb(0, OFS_STAT, 0, 0, 0, 0);
      apb(0, OFS_CDR0 + 8'h08, 0, 1, 3'h1, 10'h3C3);
      apb(0, OFS_STAT, 0, 0, 0, 0);
      apb(0, OFS_LAST, 0, 1, 3'h1, 10'h21F);
      apb(1, OFS_CH_DIS, 32'h04, 1, 3'h1, 10'h1E1);
      apb(0, OFS_LAST, 0, 1, 3'h2, 10'h099);
      apb(0, OFS_STAT, 0, 1, 3'h1, 10'h30C);
      apb(0, OFS_STAT, 0, 0, 0, 0);
      apb(0, OFS_CDR0 + 8'h0C, 0, 0, 0, 0);
      apb(1, OFS_CH_DIS, 32'h01, 1, 3'h0, 10'h111);
      apb(0, OFS_STAT, 0, 0, 0, 0);
      apb(0, OFS_CH_STAT, 0, 0, 0, 0);
      apb(1, OFS_EVT, 32'h7, 0, 0, 0);
      apb(0, 8'h08, 0, 1, 3'h3, 10'h2D2);
      apb(0, 8'h41, 0, 0, 0, 0);
      apb(1, OFS_MODE, 32'h1 << MODE_SLEEP_BIT, 0, 0, 0);
      chk(32'(sleep), 32'h0);
      apb(1, OFS_CTRL, 32'h1 << CTRL_START_BIT, 0, 0, 0);
      n = 0;
      while (sleep !== 1'b1 && n < 40) begin
         @(posedge clk);
         n++;
      end
      chk(32'(sleep), 32'h1);
      m_step(0, 0, 8'h00, 0, 1, 0, SDATA);
      apb(1, OFS_MODE, 0, 0, 0, 0);
      chk(32'(sleep), 32'h0);
      repeat (80) begin
         r = xs();
         if (r[2]) apb(0, r[3] ? rtab[r[5:4]] : OFS_CDR0 + {3'h0, r[8:6], 2'h0}, 0, r[9],
            r[12:10], r[25:16]);
         else apb(1, wtab[r[5:4]], {24'h0, r[31:24]}, r[9], r[12:10], r[25:16]);
      end
      conclude();
   end
endmodule
`default_nettype wire
